// >>> pkg/scr_defs.svh
// Field positions and reset values for the synthesizer control words.
// Assumes inclusion by the package and the design files by bare name.
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
`define SCR_WORD_W        32
`define SCR_SEL_LSB       0
`define SCR_SEL_W         3
`define SCR_SEL_R0        3'h0
`define SCR_SEL_R1        3'h1
`define SCR_SEL_R2        3'h2
`define SCR_R0_INT_LSB    15
`define SCR_R0_FRACTION_NUMERATOR_LSB   3
`define SCR_R1_PHADJ_BIT  28
`define SCR_R1_PRE_BIT    27
`define SCR_R1_PHASE_LSB  15
`define SCR_R1_MOD_LSB    3
`define SCR_R2_NOISE_LSB  29
`define SCR_R2_MUX_LSB    26
`define SCR_R2_DBL_BIT    25
`define SCR_R2_HALF_BIT   24
`define SCR_R2_RCNT_LSB   14
`define SCR_R2_DBUF_BIT   13
`define SCR_R2_CP_LSB     9
`define SCR_R2_LDF_BIT    8
`define SCR_R2_LDP_BIT    7
`define SCR_R2_PDP_BIT    6
`define SCR_R2_SLEEP_BIT  5
`define SCR_NOISE_LOWNOISE 2'h0
`define SCR_NOISE_LOWSPUR  2'h3
`define SCR_RESET_WORD    32'h0000_0000
`define SCR_LD_CNT_SLOW   6'h28
`define SCR_LD_CNT_FAST   6'h05
`define SCR_CLK_PS        25000
`define SCR_WIN_WIDE_PS   10000
`define SCR_WIN_NARROW_PS 6000
`define SCR_WIN_WIDE_CYC  (`SCR_WIN_WIDE_PS / `SCR_CLK_PS + 1)
`define SCR_WIN_NARROW_CYC (`SCR_WIN_NARROW_PS / `SCR_CLK_PS + 1)
`endif

// >>> pkg/scr_pkg.sv
// Types for the synthesizer configuration register block.
// Assumes scr_defs.svh holds the numbers.
`include "scr_defs.svh"
package scr_pkg;
   typedef struct packed {
      logic [15:0] integer_divide_value;
      logic [11:0] fraction_numerator;
   } scr_r0_t;
   typedef struct packed {
      logic        phase_adjust;
      logic        prescaler_select;
      logic [11:0] phase_word;
      logic [11:0] fraction_modulus;
   } scr_r1_t;
   typedef struct packed {
      logic [1:0] noise_mode;
      logic [2:0] test_mux_output_select;
      logic       ref_doubler;
      logic       reference_halver;
      logic [9:0] ref_count;
      logic       double_buffer;
      logic [3:0] cp_current;
      logic       lock_cycle_count_select;
      logic       lock_window_select;
      logic       pd_polarity;
      logic       software_sleep;
   } scr_r2_t;
   typedef struct packed {
      logic counters_load;
      logic vco_off;
      logic cp_tristate;
      logic outputs_off;
   } scr_pwr_t;
endpackage

// >>> design/scr_lock_detect.sv
// Digital lock detector counting consecutive in-window comparator cycles.
// Assumes comparator pulses are synchronous to clk_sys_i.
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_lock_detect (
   input  wire logic clk_sys_i,    // System clock
   input  wire logic reset_n_i,    // Async reset, active low
   input  wire logic clear_i,      // Sleep reset
   input  wire logic cycle_i,      // Comparator cycle end pulse
   input  wire logic err_ok_i,     // Error inside window this cycle
   input  wire logic fast_i,       // Count select
   output logic      locked_o      // Lock indication
);
   import scr_pkg::*;
   logic [5:0] good_cnt;
   logic [5:0] target;
   assign target = fast_i ? `SCR_LD_CNT_FAST : `SCR_LD_CNT_SLOW;
   // [RULE18] consecutive good count
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         good_cnt <= 6'h00;
         locked_o <= 1'b0;
      end else if (clear_i) begin
         good_cnt <= 6'h00;
         locked_o <= 1'b0;
      end else if (cycle_i) begin
         if (!err_ok_i) begin
            good_cnt <= 6'h00;
            locked_o <= 1'b0;
         end else if (good_cnt + 6'h01 >= target) begin
            good_cnt <= target;
            locked_o <= 1'b1;
         end else begin
            good_cnt <= good_cnt + 6'h01;
         end
      end
   end
endmodule

// >>> design/scr_regs.sv
// Serial three-wire receiver and control word decode for words 0 to 2.
// Holds the three control words and drives the mode levels derived from them.
// Assumes serial pins are asynchronous; comparator signals are on clk_sys_i.
// Assumes word 5 divider bits arrive from a neighbour block on the same clock.
// Function
// [RULE1] Low three bits select word 0, 1 or 2.
// [RULE2] Word 0 bits 30..15 give integer divide value.
// [RULE3] Host keeps integer value within prescaler limits.
// [RULE4] Word 0 bits 14..3 give fraction numerator below modulus.
// [RULE5] Phase adjust set blocks band select and resync on word 0 write.
// [RULE6] Word 1 bit 27 picks prescaler 4/5 or 8/9.
// [RULE7] Host keeps phase word below modulus.
// [RULE8] Word 1 bits 14..3 give fraction modulus.
// [RULE9] Word 2 bits 30..29 pick noise mode; low spur enables dither.
// [RULE10] Word 2 bits 28..26 pick test mux source.
// [RULE11] Word 2 bit 25 enables reference doubler, both edges active.
// [RULE12] Word 2 bit 24 inserts reference divide-by-two toggle.
// [RULE13] Word 2 bits 23..14 give reference count 1 to 1023.
// [RULE14] Word 2 bit 13 enables output divider double buffering.
// [RULE15] Word 2 bits 12..9 give charge pump current code.
// [RULE16] Word 2 bit 8 picks 40 or 5 lock cycles.
// [RULE17] Word 2 bit 7 picks 10 ns or 6 ns window; here both accept only a zero-cycle error.
// [RULE18] Lock asserts after consecutive in-window cycles; miss restarts.
// [RULE19] Host uses 00 for fractional, 11 for integer lock settings.
// [RULE20] Word 2 bit 6 sets phase detector polarity.
// [RULE21] Word 2 bit 5 sleeps the synthesizer; registers retained.
// [RULE22] Sleep loads counters, stops VCO, tristates pump, resets lock.
// [RULE23] Buffered divider bits apply on word 0 write when enabled.
// [RULE24] Words shift MSB first on rising clock, load on strobe rise.
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_regs (
   input  wire logic           clk_sys_i,      // System clock 40 MHz
   input  wire logic           reset_n_i,      // Async reset, active low
   input  wire logic           ser_clk_i,      // Serial clock pin
   input  wire logic           ser_data_i,     // Serial data pin
   input  wire logic           ser_load_i,     // Load strobe pin
   input  wire logic           pfd_cycle_i,    // Comparator cycle end pulse
   input  wire logic [7:0]     pfd_err_cyc_i,  // Phase error in clk cycles
   input  wire logic [2:0]     div_sel_new_i,  // Output divider bits, word 5
   input  wire logic           div_sel_wr_i,   // Word 5 divider bits written
   output scr_pkg::scr_r0_t    r0_o,           // Word 0 fields
   output scr_pkg::scr_r1_t    r1_o,           // Word 1 fields
   output scr_pkg::scr_r2_t    r2_o,           // Word 2 fields
   output logic                r0_write_o,     // Word 0 written pulse
   output logic                band_sel_start_o, // Band select start pulse
   output logic                resync_start_o, // Phase resync request pulse
   output logic                dither_en_o,    // Sigma-delta dither enable
   output logic                ref_both_edges_o, // Both reference edges active
   output logic                double_buffer_o, // Double buffer enable
   output logic [2:0]          div_sel_o,      // Active output divider
   output scr_pkg::scr_pwr_t   pwr_o,          // Power-down controls
   output logic                lock_o          // Digital lock detect
);
   import scr_pkg::*;

   // Pin order inside the synchroniser vector
   localparam int PIN_CLK  = 0;
   localparam int PIN_LOAD = 1;
   localparam int PIN_DATA = 2;
   localparam int N_PINS   = 3;

   // Raw pins gathered for the synchroniser loop
   logic [N_PINS-1:0] pin_raw;
   // First stage, read only by the second
   logic [N_PINS-1:0] pin_meta;
   // Second stage, safe for logic
   logic [N_PINS-1:0] pin_sync;
   // Previous samples for edge detection
   logic              sclk_q;
   logic              load_q;
   // Single-cycle edge strobes
   logic              sclk_rise;
   logic              load_rise;
   // Incoming word, newest bit at the bottom
   logic [31:0]       shift_reg;
   // Held control words, kept through sleep
   logic [31:0]       r0_word;
   logic [31:0]       r1_word;
   logic [31:0]       r2_word;
   // Select field of the word being loaded
   logic [2:0]        load_sel;
   // Word 0 write strobe
   logic              r0_wr;
   // Band select and resync both allowed
   logic              band_ok;
   // Divider bits waiting for a word 0 write
   logic [2:0]        div_pending;
   // Lock window in system clock cycles
   logic [7:0]        win_cyc;
   // Phase error inside the window
   logic              err_ok;

   // Pins gathered in a fixed order
   assign pin_raw[PIN_CLK]  = ser_clk_i;
   assign pin_raw[PIN_LOAD] = ser_load_i;
   assign pin_raw[PIN_DATA] = ser_data_i;

   // Two flip-flops per pin
   // Only stage two is read by logic, so no metastable value spreads
   for (genvar gi = 0; gi < N_PINS; gi++) begin : g_sync
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            pin_meta[gi] <= 1'b0;
            pin_sync[gi] <= 1'b0;
         end else begin
            pin_meta[gi] <= pin_raw[gi];
            pin_sync[gi] <= pin_meta[gi];
         end
      end
   end

   // Previous serial clock sample
   // Resets to the idle low level, so no false edge follows reset
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= pin_sync[PIN_CLK];
      end
   end

   // Previous load strobe sample, idle low after reset
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         load_q <= 1'b0;
      end else begin
         load_q <= pin_sync[PIN_LOAD];
      end
   end

   // Rising edges of serial clock and load strobe
   assign sclk_rise = pin_sync[PIN_CLK] & ~sclk_q;
   assign load_rise = pin_sync[PIN_LOAD] & ~load_q;

   // [RULE24] msb-first shift
   // Data passes the same two stages as the clock, so it stays aligned
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shift_reg <= `SCR_RESET_WORD;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[30:0], pin_sync[PIN_DATA]};
      end
   end

   // [RULE1] select field of the finished word
   // Only the last 32 bits before the strobe count
   assign load_sel = shift_reg[`SCR_SEL_LSB +: `SCR_SEL_W];

   // [RULE1] word 0 write strobe, one cycle
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r0_wr <= 1'b0;
      end else begin
         r0_wr <= load_rise && (load_sel == `SCR_SEL_R0);
      end
   end

   // [RULE1] load on strobe rise
   // Selects 3 to 7 belong elsewhere and are ignored here
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r0_word <= `SCR_RESET_WORD;
         r1_word <= `SCR_RESET_WORD;
         r2_word <= `SCR_RESET_WORD;
      end else if (load_rise) begin
         case (load_sel)
            `SCR_SEL_R0: r0_word <= shift_reg;
            `SCR_SEL_R1: r1_word <= shift_reg;
            `SCR_SEL_R2: r2_word <= shift_reg;
            default: ;
         endcase
      end
   end

   // [RULE2] integer field
   // Range limits are the host's concern
   assign r0_o.integer_divide_value = r0_word[`SCR_R0_INT_LSB +: 16];

   // [RULE4] fraction field
   // Passed on unchecked against the modulus
   assign r0_o.fraction_numerator   = r0_word[`SCR_R0_FRACTION_NUMERATOR_LSB +: 12];

   // [RULE5] phase adjust bit
   // Gates band select and resync below
   assign r1_o.phase_adjust         = r1_word[`SCR_R1_PHADJ_BIT];

   // [RULE6] prescaler select
   // Low picks 4/5, high picks 8/9
   assign r1_o.prescaler_select     = r1_word[`SCR_R1_PRE_BIT];

   // Phase word for resync
   // Host keeps it below the modulus
   assign r1_o.phase_word           = r1_word[`SCR_R1_PHASE_LSB +: 12];

   // [RULE8] modulus field
   // Sets the channel step of the fraction
   assign r1_o.fraction_modulus     = r1_word[`SCR_R1_MOD_LSB +: 12];

   // [RULE9] noise mode
   // Two bits, decoded into dither below
   assign r2_o.noise_mode           = r2_word[`SCR_R2_NOISE_LSB +: 2];

   // [RULE10] test mux select
   // Source choice is left to the host
   assign r2_o.test_mux_output_select = r2_word[`SCR_R2_MUX_LSB +: 3];

   // [RULE11] doubler bit
   // Low keeps only the falling edge
   assign r2_o.ref_doubler          = r2_word[`SCR_R2_DBL_BIT];

   // [RULE12] reference halver
   // Toggle stage for an even duty cycle
   assign r2_o.reference_halver     = r2_word[`SCR_R2_HALF_BIT];

   // [RULE13] reference count
   // Zero is not a legal ratio
   assign r2_o.ref_count            = r2_word[`SCR_R2_RCNT_LSB +: 10];

   // [RULE14] double buffer bit
   // Steers the divider update below
   assign r2_o.double_buffer        = r2_word[`SCR_R2_DBUF_BIT];

   // [RULE15] charge pump code
   // Chosen to suit the loop filter
   assign r2_o.cp_current           = r2_word[`SCR_R2_CP_LSB +: 4];

   // [RULE16] lock count select
   // Low counts 40 cycles, high counts 5
   assign r2_o.lock_cycle_count_select = r2_word[`SCR_R2_LDF_BIT];

   // [RULE17] lock window select
   // Low is the wide window, high the narrow one
   assign r2_o.lock_window_select   = r2_word[`SCR_R2_LDP_BIT];

   // [RULE20] detector polarity
   // High for passive or noninverting filters
   assign r2_o.pd_polarity          = r2_word[`SCR_R2_PDP_BIT];

   // [RULE21] sleep bit, registers kept
   // Words are never cleared by sleep
   assign r2_o.software_sleep       = r2_word[`SCR_R2_SLEEP_BIT];

   // [RULE9] low spur mode turns dither on
   // Every other code leaves dither off
   assign dither_en_o      = (r2_o.noise_mode == `SCR_NOISE_LOWSPUR);

   // [RULE11] doubler makes both reference edges active
   assign ref_both_edges_o = r2_o.ref_doubler;

   // [RULE14] double buffer level for the output stage
   assign double_buffer_o  = r2_o.double_buffer;

   // Word 0 write event for the stages beyond
   // Also the buffer strobe for the divider bits
   assign r0_write_o       = r0_wr;

   // [RULE5] band select and resync only without phase adjust
   // Resync enable itself lives outside this block
   assign band_ok = ~r1_o.phase_adjust;

   // [RULE5] band select start, one cycle after the write
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         band_sel_start_o <= 1'b0;
      end else begin
         band_sel_start_o <= r0_wr & band_ok;
      end
   end

   // [RULE5] resync request, one cycle after the write
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         resync_start_o <= 1'b0;
      end else begin
         resync_start_o <= r0_wr & band_ok;
      end
   end

   // [RULE14] pending divider bits from word 5
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_pending <= 3'h0;
      end else if (div_sel_wr_i) begin
         div_pending <= div_sel_new_i;
      end
   end

   // [RULE23] direct update when unbuffered
   // Buffered bits wait for the next word 0 write
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_sel_o <= 3'h0;
      end else if (div_sel_wr_i && !r2_o.double_buffer) begin
         div_sel_o <= div_sel_new_i;
      end else if (r0_wr && r2_o.double_buffer) begin
         div_sel_o <= div_pending;
      end
   end

   // [RULE22] power-down effects follow sleep one cycle late
   // Serial words keep loading while asleep
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwr_o <= '0;
      end else begin
         pwr_o.counters_load <= r2_o.software_sleep;
         pwr_o.vco_off       <= r2_o.software_sleep;
         pwr_o.cp_tristate   <= r2_o.software_sleep;
         pwr_o.outputs_off   <= r2_o.software_sleep;
      end
   end

   // [RULE17] window in whole clock cycles
   // Both windows are below one period, so only a zero error counts
   assign win_cyc = r2_o.lock_window_select ? 8'(`SCR_WIN_NARROW_CYC)
                                            : 8'(`SCR_WIN_WIDE_CYC);

   // Error compared in the cycle of the comparator pulse
   assign err_ok  = (pfd_err_cyc_i < win_cyc);

   // [RULE18] lock detector, reset by sleep
   scr_lock_detect u_lock (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .clear_i   (r2_o.software_sleep),
      .cycle_i   (pfd_cycle_i),
      .err_ok_i  (err_ok),
      .fast_i    (r2_o.lock_cycle_count_select),
      .locked_o  (lock_o)
   );
endmodule

// >>> dv/scr_regs_monitor.sv
// Port checker for the control word block.
// Assumes a bind onto scr_regs; one clock domain.
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_regs_monitor (
   input wire logic              clk_sys_i,        // Clock
   input wire logic              reset_n_i,        // Reset, low
   input wire scr_pkg::scr_r1_t  r1_o,             // Word 1
   input wire scr_pkg::scr_r2_t  r2_o,             // Word 2
   input wire logic              r0_write_o,       // Word 0 pulse
   input wire logic              band_sel_start_o, // Band start
   input wire logic              resync_start_o,   // Resync start
   input wire logic              dither_en_o,      // Dither
   input wire logic              ref_both_edges_o, // Both edges
   input wire logic              double_buffer_o,  // Double buffer
   input wire scr_pkg::scr_pwr_t pwr_o,            // Power controls
   input wire logic              lock_o            // Lock
);
   import scr_pkg::*;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   a_write_pulse: assert property (r0_write_o |=> !r0_write_o)
      else $error("word 0 pulse too long");
   a_band_start: assert property (r0_write_o && !r1_o.phase_adjust |=> band_sel_start_o)
      else $error("band select missing");
   a_band_block: assert property (r0_write_o && r1_o.phase_adjust |=> !band_sel_start_o)
      else $error("band select not blocked");
   a_band_cause: assert property (band_sel_start_o |-> $past(r0_write_o))
      else $error("band select without write");
   a_resync_same: assert property (resync_start_o == band_sel_start_o)
      else $error("resync differs");
   a_dither_mode: assert property (dither_en_o == (r2_o.noise_mode == `SCR_NOISE_LOWSPUR))
      else $error("dither mismatch");
   a_edge_both: assert property (ref_both_edges_o == r2_o.ref_doubler)
      else $error("doubler mismatch");
   a_dbuf_level: assert property (double_buffer_o == r2_o.double_buffer)
      else $error("double buffer mismatch");
   a_sleep_pwr: assert property (pwr_o == {4{$past(r2_o.software_sleep)}})
      else $error("power controls mismatch");
   a_sleep_lock: assert property (r2_o.software_sleep [*2] |-> !lock_o)
      else $error("lock while asleep");
endmodule

// >>> dv/scr_host_model.sv
// Host model writing whole words over the three-wire link.
// Assumes send is called at a falling clock edge.
`timescale 1ns/1ps
module scr_host_model (
   input  wire logic clk_sys_i,  // Bench clock
   output logic      ser_clk_o,  // Serial clock
   output logic      ser_data_o, // Serial data
   output logic      ser_load_o  // Load strobe
);
   // Idle link, clock stands low
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b0;
      ser_load_o = 1'b0;
   end
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         ser_data_o = w[i];
         repeat (4) @(negedge clk_sys_i);
         ser_clk_o = 1'b1;
         repeat (4) @(negedge clk_sys_i);
         ser_clk_o = 1'b0;
      end
      ser_load_o = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      ser_load_o = 1'b0;
      ser_data_o = ~w[0]; // Released line shows stale inverse
      repeat (4) @(negedge clk_sys_i);
   endtask
endmodule

// >>> dv/scr_regs_tb_top.sv
// Self-checking bench for the control word block.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module scr_regs_tb_top;
   import scr_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        ser_clk_i, ser_data_i, ser_load_i, lock_o;
   logic        pfd_cycle_i = 1'b0;
   logic [7:0]  pfd_err_cyc_i = 8'h00;
   logic [2:0]  div_sel_new_i = 3'h0;
   logic        div_sel_wr_i = 1'b0;
   logic [2:0]  div_sel_o;
   scr_r0_t     r0_o;
   scr_r1_t     r1_o;
   scr_r2_t     r2_o;
   scr_pwr_t    pwr_o;
   logic        r0_write_o, band_sel_start_o, resync_start_o;
   logic        dither_en_o, ref_both_edges_o, double_buffer_o;
   logic [31:0] seed = 32'h0000_d4ca;
   logic [31:0] w;
   logic [31:0] m [3] = '{default: 32'h0000_0000};
   int          n_fail = 0;
   int          check_count = 0;
   always #12.5 clk_sys_i = ~clk_sys_i;
   scr_host_model HOST (.clk_sys_i, .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
      .ser_load_o(ser_load_i));
   scr_regs DUT (.clk_sys_i, .reset_n_i, .ser_clk_i, .ser_data_i, .ser_load_i, .pfd_cycle_i,
      .pfd_err_cyc_i, .div_sel_new_i, .div_sel_wr_i, .r0_o, .r1_o, .r2_o, .r0_write_o,
      .band_sel_start_o, .resync_start_o, .dither_en_o, .ref_both_edges_o, .double_buffer_o,
      .div_sel_o, .pwr_o, .lock_o);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp();
      chk(32'(r0_o), 32'(m[0][30:3]));
      chk(32'(r1_o), 32'(m[1][28:3]));
      chk(32'(r2_o), 32'(m[2][30:5]));
   endtask
   // Model keeps selects 0 to 2 only
   task automatic wr(input logic [31:0] v);
      HOST.send(v);
      if (v[2:0] < 3'h3) m[v[2:0]] = v;
      cmp();
   endtask
   task automatic dv(input logic [2:0] n);
      div_sel_new_i = n;
      div_sel_wr_i = 1'b1;
      @(negedge clk_sys_i);
      div_sel_wr_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
   endtask
   task automatic pl(input int n, input logic [7:0] e);
      repeat (n) begin
         pfd_err_cyc_i = e;
         pfd_cycle_i = 1'b1;
         @(negedge clk_sys_i);
         pfd_cycle_i = 1'b0;
         repeat (2) @(negedge clk_sys_i);
      end
   endtask
   task automatic lk(input int n);
      pl(1, 8'h01);
      pl(n - 1, 8'h00);
      chk(32'(lock_o), 32'h0000_0000);
      pl(1, 8'h00);
      chk(32'(lock_o), 32'h0000_0001);
      pl(1, 8'h01);
      chk(32'(lock_o), 32'h0000_0000);
      pl(n, 8'h00);
      chk(32'(lock_o), 32'h0000_0001);
      $display("test lock %0d done", n);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog on the whole run
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      n_fail++;
      test_done();
   end
   initial begin
      repeat (4) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      cmp();
      dv(3'h3);
      chk(32'(div_sel_o), 32'h0000_0003);
      wr(32'h0000_6002);
      dv(3'h5);
      chk(32'(div_sel_o), 32'h0000_0003);
      wr(32'h4000_0000);
      chk(32'(div_sel_o), 32'h0000_0005);
      $display("test buffer done");
      for (int i = 0; i < 16; i++) begin
         w = rnd();
         w[2:0] = i[2:0];
         w[30] = 1'b1;
         w[26] = 1'b0;
         w[14] = (i[2:0] != 3'h0);
         w[8] = w[7];
         w[5] = 1'b0;
         wr(w);
      end
      $display("test random done");
      wr(32'h0000_4002);
      lk(40);
      wr(32'h0000_4182);
      lk(5);
      wr(32'h0000_4022);
      chk(32'(lock_o), 32'h0000_0000);
      chk(32'(pwr_o), 32'h0000_000f);
      wr(32'h4000_0008);
      wr(32'h0000_4002);
      chk(32'(pwr_o), 32'h0000_0000);
      $display("test sleep done");
      test_done();
   end
endmodule
bind scr_regs scr_regs_monitor MON (.clk_sys_i, .reset_n_i, .r1_o, .r2_o, .r0_write_o,
   .band_sel_start_o, .resync_start_o, .dither_en_o, .ref_both_edges_o, .double_buffer_o,
   .pwr_o, .lock_o);
